/* macfs_regs.sv */
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module macfs_regs
	import macfs_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [REG_AW-1:0]         s_axi_awaddr,
	input  wire logic [2:0]                s_axi_awprot,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [WORD_W-1:0]         s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [REG_AW-1:0]         s_axi_araddr,
	input  wire logic [2:0]                s_axi_arprot,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [WORD_W-1:0]              s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      tx_done,
	input  wire macfs_tx_event_t           tx_event,
	input  wire logic                      rx_done,
	input  wire macfs_rx_event_t           rx_event,
	output logic [HASH_W-1:0]              hash_filter,
	output logic [NUM_SLOTS-1:0][MAC_ADDR_W-1:0] unicast_addr
);

	// Filter, address and counter storage.
	logic [WORD_W-1:0]      hash_filter_low;
	logic [WORD_W-1:0]      hash_filter_high;
	logic [WORD_W-1:0]      unicast_addr_low  [NUM_SLOTS];
	logic [ADDR_HIGH_W-1:0] unicast_addr_high [NUM_SLOTS];
	logic [CNT_MAX_W-1:0]   cnt               [NUM_CNT];
	logic [NUM_CNT-1:0]     cnt_inc;
	logic [NUM_CNT-1:0]     cnt_clr;

	// Write channel holding state.
	logic                   aw_held;
	logic                   w_held;
	logic [REG_AW-1:0]      wr_addr;
	logic [WORD_W-1:0]      wr_data;
	logic [3:0]             wr_strb;

	// Merges a write into a register under its byte strobes.
	function automatic logic [WORD_W-1:0] merge_strb(
		input logic [WORD_W-1:0] old_val,
		input logic [WORD_W-1:0] new_val,
		input logic [3:0]        strb
	);
		logic [WORD_W-1:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Handshakes on the five channels.
	wire aw_fire  = s_axi_awvalid & s_axi_awready;
	wire w_fire   = s_axi_wvalid & s_axi_wready;
	wire b_fire   = s_axi_bvalid & s_axi_bready;
	wire ar_fire  = s_axi_arvalid & s_axi_arready;
	wire r_fire   = s_axi_rvalid & s_axi_rready;
	wire do_write = aw_held & w_held & ~s_axi_bvalid;

	// Write address decode.
	wire [REG_AW-1:0] wr_slot_ofs = wr_addr - OFS_SLOT_BASE;
	wire [1:0]        wr_slot     = wr_slot_ofs[SLOT_SHIFT +: 2];
	wire              wr_is_slot  = (wr_addr >= OFS_SLOT_BASE) & (wr_addr < OFS_SLOT_END);
	wire              wr_is_cnt   = (wr_addr >= OFS_CNT_BASE) & (wr_addr < OFS_CNT_END);
	wire              wr_hash_lo  = (wr_addr[REG_AW-1:WORD_SHIFT] == OFS_HASH_LOW[REG_AW-1:WORD_SHIFT]);
	wire              wr_hash_hi  = (wr_addr[REG_AW-1:WORD_SHIFT] == OFS_HASH_HIGH[REG_AW-1:WORD_SHIFT]);
	wire              wr_high     = wr_addr[HIGH_SEL_BIT];
	wire              wr_mapped   = wr_hash_lo | wr_hash_hi | wr_is_slot | wr_is_cnt;

	// Read address decode.
	wire [REG_AW-1:0] rd_slot_ofs = s_axi_araddr - OFS_SLOT_BASE;
	wire [1:0]        rd_slot     = rd_slot_ofs[SLOT_SHIFT +: 2];
	wire [REG_AW-1:0] rd_cnt_ofs  = s_axi_araddr - OFS_CNT_BASE;
	wire [4:0]        rd_cnt_idx  = rd_cnt_ofs[WORD_SHIFT +: 5];
	wire              rd_is_slot  = (s_axi_araddr >= OFS_SLOT_BASE) & (s_axi_araddr < OFS_SLOT_END);
	wire              rd_is_cnt   = (s_axi_araddr >= OFS_CNT_BASE) & (s_axi_araddr < OFS_CNT_END);
	wire              rd_hash_lo  = (s_axi_araddr[REG_AW-1:WORD_SHIFT] == OFS_HASH_LOW[REG_AW-1:WORD_SHIFT]);
	wire              rd_hash_hi  = (s_axi_araddr[REG_AW-1:WORD_SHIFT] == OFS_HASH_HIGH[REG_AW-1:WORD_SHIFT]);
	wire              rd_high     = s_axi_araddr[HIGH_SEL_BIT];
	wire              rd_mapped   = rd_hash_lo | rd_hash_hi | rd_is_slot | rd_is_cnt;

	// Read data selection; the slot high word keeps its top half zero.
	wire [WORD_W-1:0] rd_slot_val = rd_high ?
		{{(WORD_W-ADDR_HIGH_W){1'b0}}, unicast_addr_high[rd_slot]} :
		unicast_addr_low[rd_slot];
	wire [WORD_W-1:0] rd_cnt_val  = {{(WORD_W-CNT_MAX_W){1'b0}}, cnt[rd_cnt_idx]};
	wire [WORD_W-1:0] rd_mux      = rd_hash_lo ? hash_filter_low :
		rd_hash_hi ? hash_filter_high :
		rd_is_slot ? rd_slot_val :
		rd_is_cnt  ? rd_cnt_val : REG_RESET;

	// Transmit outcome decode; an underrun frame touches no other counter.
	wire tx_clean   = tx_done & ~tx_event.underrun;
	wire tx_no_loss = tx_clean & ~tx_event.carrier_lost;
	wire tx_multi   = (tx_event.collisions >= MULTI_COL_MIN) &
		(tx_event.collisions <= MULTI_COL_MAX);
	assign cnt_inc[CNT_TX_OK]         = tx_clean & tx_event.sent;
	assign cnt_inc[CNT_SINGLE_COL]    = tx_no_loss & tx_event.sent &
		(tx_event.collisions == ONE_COL);
	assign cnt_inc[CNT_MULTI_COL]     = tx_no_loss & tx_event.sent & tx_multi;
	assign cnt_inc[CNT_DEFERRED]      = tx_clean & tx_event.deferred &
		(tx_event.collisions == NO_COL);
	assign cnt_inc[CNT_LATE_COL]      = tx_no_loss & tx_event.late_collision;
	assign cnt_inc[CNT_EXCESS_COL]    = tx_clean & (tx_event.collisions == EXCESS_COL);
	assign cnt_inc[CNT_CARRIER_ERR]   = tx_clean & tx_event.half_duplex &
		tx_event.carrier_lost & (tx_event.collisions != EXCESS_COL);
	assign cnt_inc[CNT_UNDERRUN]      = tx_done & tx_event.underrun;
	assign cnt_inc[CNT_HEARTBEAT_ERR] = tx_clean & tx_event.heartbeat_miss;

	// Receive outcome decode; an address-matched receive-error frame touches no other counter.
	wire rx_sym     = rx_done & rx_event.addr_match & rx_event.symbol_err;
	wire rx_clean   = rx_done & ~rx_sym;
	wire rx_match   = rx_clean & rx_event.addr_match;
	wire rx_in_size = (rx_event.length >= MIN_FRAME_LEN) &
		(rx_event.length <= MAX_FRAME_LEN);
	wire rx_over    = rx_event.length > MAX_FRAME_LEN;
	wire rx_under   = rx_event.length < MIN_FRAME_LEN;
	wire rx_err     = rx_event.crc_bad | rx_event.symbol_err;
	assign cnt_inc[CNT_RX_OK]         = rx_match & rx_in_size & ~rx_err;
	assign cnt_inc[CNT_CRC_ERR]       = rx_match & rx_in_size & rx_event.crc_bad &
		~rx_event.odd_bits;
	assign cnt_inc[CNT_ALIGN_ERR]     = rx_match & rx_in_size & rx_event.crc_bad &
		rx_event.odd_bits;
	assign cnt_inc[CNT_SYMBOL_ERR]    = rx_sym;
	assign cnt_inc[CNT_OVERSIZE_GOOD] = rx_clean & rx_over & ~rx_err;
	assign cnt_inc[CNT_OVERSIZE_BAD]  = rx_clean & rx_over & rx_err;
	assign cnt_inc[CNT_UNDERSIZE]     = rx_clean & rx_under & ~rx_err;
	assign cnt_inc[CNT_RX_DISCARD]    = rx_match & rx_event.no_buffer;

	// Write address channel: one write in flight, ready again after the response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			wr_addr       <= '0;
			s_axi_awready <= 1'b1;
		end else if (aw_fire) begin
			aw_held       <= 1'b1;
			wr_addr       <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else begin
			if (do_write) aw_held <= 1'b0;
			if (b_fire) s_axi_awready <= 1'b1;
		end
	end

	// Write data channel, taken independently of the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held       <= 1'b0;
			wr_data      <= '0;
			wr_strb      <= '0;
			s_axi_wready <= 1'b1;
		end else if (w_fire) begin
			w_held       <= 1'b1;
			wr_data      <= s_axi_wdata;
			wr_strb      <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else begin
			if (do_write) w_held <= 1'b0;
			if (b_fire) s_axi_wready <= 1'b1;
		end
	end

	// Write response; counters accept writes silently, holes answer an error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (b_fire) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Hash filter words.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hash_filter_low  <= REG_RESET;
			hash_filter_high <= REG_RESET;
		end else if (do_write) begin
			if (wr_hash_lo) hash_filter_low <= merge_strb(hash_filter_low, wr_data, wr_strb);
			if (wr_hash_hi) hash_filter_high <= merge_strb(hash_filter_high, wr_data, wr_strb);
		end
	end
	assign hash_filter = {hash_filter_high, hash_filter_low};

	// Specific address slots, one pair of words each.
	for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
		logic [WORD_W-1:0] high_merged;
		wire               wr_this = do_write & wr_is_slot & (wr_slot == 2'(s));
		assign high_merged = merge_strb({{(WORD_W-ADDR_HIGH_W){1'b0}}, unicast_addr_high[s]},
			wr_data, wr_strb);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				unicast_addr_low[s]  <= REG_RESET;
				unicast_addr_high[s] <= REG_RESET[ADDR_HIGH_W-1:0];
			end else if (wr_this & wr_high) begin
				unicast_addr_high[s] <= high_merged[ADDR_HIGH_W-1:0];
			end else if (wr_this) begin
				unicast_addr_low[s] <= merge_strb(unicast_addr_low[s], wr_data, wr_strb);
			end
		end
		assign unicast_addr[s] = {unicast_addr_high[s], unicast_addr_low[s]};
	end

	// Read channel: data are captured at the address handshake.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= REG_RESET;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ar_fire) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_mux;
			s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (r_fire) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Statistics counters: clear on read, saturate at the counter's own width.
	for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
		localparam logic [CNT_MAX_W-1:0] LIMIT = CNT_MAX_W'((33'd1 << CNT_W[i]) - 33'd1);
		assign cnt_clr[i] = ar_fire & rd_is_cnt & (rd_cnt_idx == 5'(i));
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cnt[i] <= '0;
			end else if (cnt_clr[i]) begin
				cnt[i] <= cnt_inc[i] ? CNT_MAX_W'(1) : '0;
			end else if (cnt_inc[i] && (cnt[i] != LIMIT)) begin
				cnt[i] <= cnt[i] + CNT_MAX_W'(1);
			end
		end
	end

	// Protection bits are accepted and carry no meaning here.
	wire unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

/* macfs_pkg.sv */
package macfs_pkg;

	// Register map, byte addresses within the block.
	localparam int         REG_AW        = 8;
	localparam logic [7:0] OFS_HASH_LOW  = 8'h00;
	localparam logic [7:0] OFS_HASH_HIGH = 8'h04;
	localparam logic [7:0] OFS_SLOT_BASE = 8'h08;
	localparam logic [7:0] OFS_SLOT_END  = 8'h28;
	localparam logic [7:0] OFS_CNT_BASE  = 8'h40;
	localparam logic [7:0] OFS_CNT_END   = 8'h84;
	localparam int         SLOT_SHIFT    = 3;
	localparam int         WORD_SHIFT    = 2;
	localparam int         HIGH_SEL_BIT  = 2;

	// Sizes of the filter and the address slots.
	localparam int NUM_SLOTS   = 4;
	localparam int HASH_W      = 64;
	localparam int WORD_W      = 32;
	localparam int ADDR_HIGH_W = 16;
	localparam int MAC_ADDR_W  = 48;
	localparam logic [WORD_W-1:0] REG_RESET = 32'h0000_0000;

	// Statistics counters: index and width of each.
	localparam int NUM_CNT           = 17;
	localparam int CNT_MAX_W         = 24;
	localparam int CNT_TX_OK         = 0;
	localparam int CNT_SINGLE_COL    = 1;
	localparam int CNT_MULTI_COL     = 2;
	localparam int CNT_RX_OK         = 3;
	localparam int CNT_CRC_ERR       = 4;
	localparam int CNT_ALIGN_ERR     = 5;
	localparam int CNT_DEFERRED      = 6;
	localparam int CNT_LATE_COL      = 7;
	localparam int CNT_EXCESS_COL    = 8;
	localparam int CNT_CARRIER_ERR   = 9;
	localparam int CNT_UNDERRUN      = 10;
	localparam int CNT_SYMBOL_ERR    = 11;
	localparam int CNT_OVERSIZE_GOOD = 12;
	localparam int CNT_OVERSIZE_BAD  = 13;
	localparam int CNT_UNDERSIZE     = 14;
	localparam int CNT_HEARTBEAT_ERR = 15;
	localparam int CNT_RX_DISCARD    = 16;
	localparam int CNT_W [NUM_CNT] = '{24, 16, 16, 24, 8, 8, 16, 8, 8,
		8, 8, 8, 8, 8, 8, 8, 16};

	// Frame limits and collision figures.
	localparam logic [15:0] MIN_FRAME_LEN  = 16'h0040;
	localparam logic [15:0] MAX_FRAME_LEN  = 16'h05ee;
	localparam logic [4:0]  ONE_COL        = 5'h01;
	localparam logic [4:0]  MULTI_COL_MIN  = 5'h02;
	localparam logic [4:0]  MULTI_COL_MAX  = 5'h0f;
	localparam logic [4:0]  EXCESS_COL     = 5'h10;
	localparam logic [4:0]  NO_COL         = 5'h00;

	// AXI4-Lite response codes.
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Outcome of one transmitted frame, valid with its done strobe.
	typedef struct packed {
		logic       sent;           // Frame went out on the wire.
		logic       underrun;       // Transmit DMA underrun.
		logic       carrier_lost;   // Carrier not seen and held a slot time.
		logic       half_duplex;    // Link was half duplex.
		logic       deferred;       // First attempt deferred on carrier.
		logic       late_collision; // Collision after the slot time.
		logic       heartbeat_miss; // No collision signal after transmit.
		logic [4:0] collisions;     // Collisions seen, 16 means abandoned.
	} macfs_tx_event_t;

	// Outcome of one received frame, valid with its done strobe.
	typedef struct packed {
		logic        addr_match;  // Address recognised.
		logic        symbol_err;  // Receive-error input seen.
		logic        crc_bad;     // Check sequence failed.
		logic        odd_bits;    // Not a whole number of bytes.
		logic        no_buffer;   // Could not be stored to memory.
		logic [15:0] length;      // Length in bytes.
	} macfs_rx_event_t;

endpackage

/* macfs_regs_props.sv */
`timescale 1ns/1ps
module macfs_regs_props
	import macfs_pkg::*;
(
	input wire logic                                 aclk,
	input wire logic                                 aresetn,
	input wire logic [REG_AW-1:0]                    s_axi_awaddr,
	input wire logic                                 s_axi_awvalid,
	input wire logic                                 s_axi_awready,
	input wire logic [WORD_W-1:0]                    s_axi_wdata,
	input wire logic [3:0]                           s_axi_wstrb,
	input wire logic                                 s_axi_wvalid,
	input wire logic                                 s_axi_wready,
	input wire logic                                 s_axi_bvalid,
	input wire logic [REG_AW-1:0]                    s_axi_araddr,
	input wire logic                                 s_axi_arvalid,
	input wire logic                                 s_axi_arready,
	input wire logic [WORD_W-1:0]                    s_axi_rdata,
	input wire logic                                 s_axi_rvalid,
	input wire logic [HASH_W-1:0]                    hash_filter,
	input wire logic [NUM_SLOTS-1:0][MAC_ADDR_W-1:0] unicast_addr
);
	// Handshakes; only full-strobe writes let a register be predicted whole.
	wire        wr_hs   = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire        full_wr = wr_hs && s_axi_wstrb == 4'hf;
	wire        rd_hs   = s_axi_arvalid && s_axi_arready;
	wire [15:0] wlo     = s_axi_wdata[15:0];
	default clocking dcb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_hash_low;
		full_wr && s_axi_awaddr == OFS_HASH_LOW |-> ##2 hash_filter[31:0] == $past(s_axi_wdata, 2);
	endproperty
	a_hash_low: assert property (p_hash_low) else $error("hash low word not loaded");
	property p_hash_high;
		full_wr && s_axi_awaddr == OFS_HASH_HIGH |-> ##2 hash_filter[63:32] == $past(s_axi_wdata, 2);
	endproperty
	a_hash_high: assert property (p_hash_high) else $error("hash high word not loaded");
	property p_slot_high;
		full_wr && s_axi_awaddr == OFS_SLOT_BASE + 8'h04 |-> ##2 unicast_addr[0][47:32] == $past(wlo, 2);
	endproperty
	a_slot_high: assert property (p_slot_high) else $error("slot high half not loaded");
	// Reset must clear the filter even while reset is still held.
	property p_reset_zero;
		disable iff (1'b0) !aresetn |=> hash_filter == '0 && unicast_addr == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("filter not cleared by reset");
	property p_tx_ok_width;
		rd_hs && s_axi_araddr == OFS_CNT_BASE |=> s_axi_rvalid && s_axi_rdata[31:24] == 8'h00;
	endproperty
	a_tx_ok_width: assert property (p_tx_ok_width) else $error("wide counter overflows");
	property p_crc_width;
		rd_hs && s_axi_araddr == OFS_CNT_BASE + 8'h10 |=> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_crc_width: assert property (p_crc_width) else $error("byte counter overflows");
	property p_rd_answer;
		rd_hs |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_wr_answer;
		wr_hs |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer mistimed");
endmodule

/* macfs_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin \
	n_checks++; \
	if ((a) !== (e)) begin \
		errors++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
	end \
end
module macfs_regs_tb;
	import macfs_pkg::*;
	logic                                 aclk = 1'b0;
	logic                                 aresetn = 1'b0;
	logic [REG_AW-1:0]                    s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0]                           s_axi_awprot = '0, s_axi_arprot = '0;
	logic                                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic                                 s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
	logic                                 s_axi_rready = 1'b0, tx_done = 1'b0, rx_done = 1'b0;
	logic [WORD_W-1:0]                    s_axi_wdata = '0;
	logic [3:0]                           s_axi_wstrb = '0;
	macfs_tx_event_t                      tx_event = '0;
	macfs_rx_event_t                      rx_event = '0;
	logic                                 s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic                                 s_axi_arready, s_axi_rvalid;
	logic [1:0]                           s_axi_bresp, s_axi_rresp, rsp;
	logic [WORD_W-1:0]                    s_axi_rdata, rd, d;
	logic [HASH_W-1:0]                    hash_filter;
	logic [NUM_SLOTS-1:0][MAC_ADDR_W-1:0] unicast_addr;
	logic [3:0]                           st;
	int                                   errors = 0, n_checks = 0, seed = 23;
	int                                   cnt [NUM_CNT];
	logic [WORD_W-1:0]                    mreg [10];
	localparam logic [15:0] LENS [4] = '{16'h003f, 16'h0040, 16'h05ee, 16'h05ef};
	// Free-running system clock.
	always #2.5 aclk = ~aclk;
	macfs_regs dut_u (.*);
	// Bus master; each task starts on a fresh edge so no signal is set twice at once.
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rdw(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Reference model: saturating counters and the event decode.
	function automatic void bump(int i);
		if (cnt[i] < (1 << CNT_W[i]) - 1) cnt[i]++;
	endfunction
	function automatic void tx_model(macfs_tx_event_t t);
		logic ok = t.sent && !t.carrier_lost;
		if (t.underrun) begin
			bump(CNT_UNDERRUN);
			return;
		end
		if (t.sent) bump(CNT_TX_OK);
		if (ok && t.collisions == ONE_COL) bump(CNT_SINGLE_COL);
		if (ok && t.collisions inside {[MULTI_COL_MIN:MULTI_COL_MAX]}) bump(CNT_MULTI_COL);
		if (t.deferred && t.collisions == NO_COL) bump(CNT_DEFERRED);
		if (t.late_collision && !t.carrier_lost) bump(CNT_LATE_COL);
		if (t.collisions == EXCESS_COL) bump(CNT_EXCESS_COL);
		if (t.half_duplex && t.carrier_lost) bump(CNT_CARRIER_ERR);
		if (t.heartbeat_miss) bump(CNT_HEARTBEAT_ERR);
	endfunction
	function automatic void rx_model(macfs_rx_event_t r);
		logic err = r.crc_bad | r.symbol_err;
		logic fit = r.length >= MIN_FRAME_LEN && r.length <= MAX_FRAME_LEN;
		if (r.addr_match && r.symbol_err) begin
			bump(CNT_SYMBOL_ERR);
			return;
		end
		if (r.length > MAX_FRAME_LEN && !err) bump(CNT_OVERSIZE_GOOD);
		if (r.length > MAX_FRAME_LEN && err) bump(CNT_OVERSIZE_BAD);
		if (r.length < MIN_FRAME_LEN && !err) bump(CNT_UNDERSIZE);
		if (r.addr_match && fit) bump(!r.crc_bad ? CNT_RX_OK : r.odd_bits ? CNT_ALIGN_ERR : CNT_CRC_ERR);
		if (r.addr_match && r.no_buffer) bump(CNT_RX_DISCARD);
	endfunction
	// Random back-to-back frame outcomes; sat forces one byte counter to its ceiling.
	task automatic burst(input int n, input bit sat);
		macfs_tx_event_t t;
		macfs_rx_event_t r;
		logic            td, rdn;
		int              k2;
		for (int k = 0; k < n; k++) begin
			@(posedge aclk);
			t = $bits(t)'($random(seed));
			r = $bits(r)'($random(seed));
			td = sat | 1'($random(seed));
			rdn = 1'($random(seed));
			k2 = $unsigned($random(seed)) % 6;
			t.collisions = 5'($unsigned($random(seed)) % 17);
			t.sent &= t.collisions != EXCESS_COL;
			t.carrier_lost &= t.collisions != EXCESS_COL;
			t.late_collision &= t.collisions != NO_COL;
			t.underrun &= !sat;
			t.heartbeat_miss |= sat;
			r.odd_bits &= r.crc_bad;
			if (k2 < 4) r.length = LENS[k2];
			else r.length &= 16'h07ff;
			tx_done <= td;
			tx_event <= t;
			rx_done <= rdn;
			rx_event <= r;
			if (td) tx_model(t);
			if (rdn) rx_model(r);
		end
		@(posedge aclk);
		tx_done <= 1'b0;
		rx_done <= 1'b0;
	endtask
	task automatic chk_regs();
		for (int i = 0; i < 10; i++) begin
			rdw(8'(4 * i));
			`CHK({rsp, rd}, {RESP_OKAY, mreg[i]})
		end
		`CHK(hash_filter, {mreg[1], mreg[0]})
		for (int n = 0; n < NUM_SLOTS; n++) `CHK(unicast_addr[n], {mreg[3 + 2 * n][15:0], mreg[2 + 2 * n]})
	endtask
	task automatic chk_cnt();
		for (int i = 0; i < NUM_CNT; i++) begin
			rdw(OFS_CNT_BASE + 8'(4 * i));
			`CHK(rd, 32'(cnt[i]))
			cnt[i] = 0;
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog well beyond the thousand or so cycles the sequence needs.
	initial begin
		#100us;
		errors++;
		finish_test();
	end
	initial begin
		foreach (cnt[i]) cnt[i] = 0;
		foreach (mreg[i]) mreg[i] = '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		chk_regs();
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 10; i++) begin
				st = p ? 4'($random(seed)) : 4'hf;
				d = $random(seed);
				wr(8'(4 * i), d, st);
				`CHK(rsp, RESP_OKAY)
				for (int b = 0; b < 4; b++) if (st[b]) mreg[i][8 * b +: 8] = d[8 * b +: 8];
				if (i > 2 && i % 2 == 1) mreg[i][31:16] = '0;
			end
			chk_regs();
		end
		wr(8'h30, 32'hffff_ffff, 4'hf);
		`CHK(rsp, RESP_SLVERR)
		rdw(8'h30);
		`CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
		burst(200, 1'b0);
		chk_cnt();
		chk_cnt();
		wr(OFS_CNT_BASE, 32'hffff_ffff, 4'hf);
		`CHK(rsp, RESP_OKAY)
		burst(300, 1'b1);
		chk_cnt();
		burst(50, 1'b0);
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (cnt[i]) cnt[i] = 0;
		foreach (mreg[i]) mreg[i] = '0;
		chk_cnt();
		chk_regs();
		finish_test();
	end
endmodule
bind macfs_regs macfs_regs_props chk_u (.*);
